//--- include/asc_map.svh
// offsets, fields, reset values and counts of the sequencer control block
// assumes byte addresses on an 8-bit bus
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// ===
// global registers (byte offsets)
`define ASC_OFS_ACTIVE 8'h00
`define ASC_OFS_IRQ_MASK 8'h04
`define ASC_OFS_RAW_IRQ 8'h08
`define ASC_OFS_MSK_CLR 8'h0C
`define ASC_OFS_OVERFLOW 8'h10
`define ASC_OFS_TRIG_SEL 8'h14
`define ASC_OFS_UNDERFLOW 8'h18
`define ASC_OFS_PRIORITY 8'h20
`define ASC_OFS_PHASE 8'h24
`define ASC_OFS_INITIATE 8'h28
`define ASC_OFS_AVG_CTL 8'h30
`define ASC_OFS_CMP_CLR 8'h34

// ===
// per-sequencer windows: base + n * stride, sub-register index in [4:2]
`define ASC_SEQ_WIN_FIRST 3'h2
`define ASC_SEQ_WIN_LAST 3'h5
`define ASC_SUB_INSEL 3'h0
`define ASC_SUB_STEPCTL 3'h1
`define ASC_SUB_QUEUE 3'h2
`define ASC_SUB_QSTATE 3'h3

// ===
// fields
`define ASC_BUSY_POS 16
`define ASC_CMP_IRQ_POS 16
`define ASC_QS_HEAD_POS 4
`define ASC_QS_EMPTY_POS 8
`define ASC_QS_FULL_POS 12
`define ASC_CTL_END_BIT 1
`define ASC_CTL_IE_BIT 2
`define ASC_RESULT_W 10
`define ASC_PRI_RESET 16'h3210
`define ASC_AVG_MAX 3'h6

// ===
// trigger source codes, one nibble per sequencer
`define ASC_TRIG_PROC 4'h0
`define ASC_TRIG_ACMP 4'h1
`define ASC_TRIG_PIN 4'h4
`define ASC_TRIG_TIMER 4'h5
`define ASC_TRIG_CONT 4'hF

// ===
// sizes and clocking
`define ASC_SS0_DEPTH 8
`define ASC_SS12_DEPTH 4
`define ASC_SS3_DEPTH 1
`define ASC_CONV_CLK_MHZ 16

`endif

//--- include/asc_pkg.sv
// types shared by the sample sequencer control block
// assumes asc_map.svh is on the include path
package asc_pkg;

  // ===
  // engine states
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_START,
    ASC_WAIT,
    ASC_STORE
  } asc_state_t;

  // ===
  // one conversion request to the analog converter
  typedef struct packed {
    logic [2:0] channel;
    logic [3:0] phase;
  } asc_conv_req_t;

endpackage

//--- hdl/asc_top.sv
// sample sequencer control: four sequencers, result queues, triggers,
// priority, averaging, interrupts and dma burst requests
// assumes an Avalon-MM master and a converter that answers
// each conv_start with one conv_done pulse
//
// Contract
// (RULE_01) four sequencers, steps and queue depth 8, 4, 4 and 1
// (RULE_02) queue word is 32 bits, conversion value in low 10 bits
// (RULE_03) software programs steps before enabling a sequencer
// (RULE_04) processor trigger plus initiate bit starts an enabled sequencer
// (RULE_05) one input may be used by several steps
// (RULE_06) each step has an irq enable; raw irq after each such step
// (RULE_07) last-sample flag ends the sequence at any step position
// (RULE_08) queues are circular; each result read pops the oldest entry
// (RULE_09) queue state shows head, tail, full and empty
// (RULE_10) result into a full queue is dropped and sets overflow flag
// (RULE_11) overflow and underflow are kept per sequencer in own registers
// (RULE_12) sequencing logic runs from the converter clock domain
// (RULE_13) raw irqs always visible; only mask-enabled ones reach irq
// (RULE_14) writing one clears a sequencer irq; zero does nothing
// (RULE_15) writing one clears a comparator irq
// (RULE_16) per sequencer burst dma request when an irq-enabled step completes
// (RULE_17) dma arbitration size power of two matching irq-enabled steps; no size is given here, dma_req pulses once per such step
// (RULE_18) concurrent triggers served by priority value, zero highest
// (RULE_19) software gives active sequencers distinct priorities
// (RULE_20) trigger: processor default, comparator, pin edge, timer, continuous
// (RULE_21) sample instant delayable in 22.5 degree steps up to 337.5
// (RULE_22) one averager, off at reset, up to 64 conversions per entry
// (RULE_23) setting 2 averages four; step irq after averaged value stored
// (RULE_24) continuous trigger rerequests right after the last step
// (RULE_25) read of empty queue keeps pointers, sets underflow flag
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
`include "asc_map.svh"

module asc_top #(
  parameter int SS0_DEPTH = `ASC_SS0_DEPTH,
  parameter int SS12_DEPTH = `ASC_SS12_DEPTH,
  parameter int SS3_DEPTH = `ASC_SS3_DEPTH
) (
  input wire logic sys_clk, // converter-rate clock
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // high until the access is answered
  input wire logic trig_acmp, // analog comparator event pulse
  input wire logic trig_pin, // external trigger pin level
  input wire logic trig_timer, // timer event pulse
  input wire logic [7:0] cmp_event, // digital comparator event pulses
  output logic conv_start, // one-cycle conversion start
  output asc_pkg::asc_conv_req_t conv_req, // channel and phase of that start
  input wire logic conv_done, // conversion finished pulse
  input wire logic [9:0] conv_data, // conversion value with conv_done
  output logic [3:0] dma_req, // burst request pulse per sequencer
  output logic irq // masked interrupt level
);

  // ===
  // helpers
  function automatic logic [3:0] seq_depth(input logic [1:0] n);
    unique case (n)
      2'd0: seq_depth = 4'(SS0_DEPTH);
      2'd1, 2'd2: seq_depth = 4'(SS12_DEPTH);
      2'd3: seq_depth = 4'(SS3_DEPTH);
    endcase
  endfunction

  function automatic logic [2:0] wrap_inc(input logic [2:0] p, input logic [1:0] n);
    if ({1'b0, p} == seq_depth(n) - 4'd1) begin
      wrap_inc = 3'd0;
    end else begin
      wrap_inc = p + 3'd1;
    end
  endfunction

  // ===
  // registers
  logic [3:0] enable_q;
  logic [3:0] mask_q;
  logic mask_cmp_q;
  logic [3:0] raw_q;
  logic [7:0] cmp_raw_q;
  logic [3:0] ovf_q;
  logic [3:0] unf_q;
  logic [15:0] trig_sel_q;
  logic [15:0] pri_q;
  logic [3:0] phase_q;
  logic [2:0] avg_q;
  logic [31:0] insel_q [4];
  logic [31:0] stepctl_q [4];
  logic [9:0] mem_q [4][8];
  logic [2:0] head_q [4];
  logic [2:0] tail_q [4];
  logic [3:0] cnt_q [4];
  logic [3:0] pend_q;
  logic pin_q;
  asc_pkg::asc_state_t state_q;
  logic [1:0] cur_q;
  logic [2:0] step_q;
  logic [6:0] avg_cnt_q;
  logic [15:0] acc_q;

  // ===
  // bus decode: every access is answered one edge after it is seen
  logic acc_v;
  logic wr_v;
  logic rd_v;
  logic in_seq;
  logic [1:0] sel_seq;
  logic [2:0] sub;
  logic [2:0] win;

  assign acc_v = (avs_read | avs_write) & avs_waitrequest;
  assign wr_v = avs_write & avs_waitrequest;
  assign rd_v = avs_read & avs_waitrequest;
  assign win = avs_address[7:5];
  assign in_seq = (win >= `ASC_SEQ_WIN_FIRST) && (win <= `ASC_SEQ_WIN_LAST);
  assign sel_seq = 2'(win - `ASC_SEQ_WIN_FIRST);
  assign sub = avs_address[4:2];

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_v && (avs_address == ofs);
  endfunction

  // ===
  // engine-side decode
  logic [2:0] cur_chan;
  logic [3:0] cur_ctl;
  logic last_step;
  logic push_v;
  logic [9:0] avg_val;
  logic [3:0] pop_v;
  logic [3:0] hit_v;
  logic [1:0] grant;
  logic [3:0] ready_v;
  logic [6:0] avg_total;

  assign cur_chan = insel_q[cur_q][{step_q, 2'b00} +: 3]; // RULE_05
  assign cur_ctl = stepctl_q[cur_q][{step_q, 2'b00} +: 4];
  assign last_step = cur_ctl[`ASC_CTL_END_BIT] ||
                     ({1'b0, step_q} == seq_depth(cur_q) - 4'd1); // RULE_07 RULE_01
  assign push_v = (state_q == asc_pkg::ASC_STORE);
  assign avg_val = 10'(acc_q >> avg_q); // RULE_22
  assign avg_total = 7'(7'd1 << avg_q); // RULE_23
  assign ready_v = pend_q & enable_q;

  // lowest priority value wins; equal values fall to the lower index
  function automatic logic [1:0] arbitrate(input logic [3:0] req, input logic [15:0] pri);
    logic [1:0] best;
    logic [1:0] best_pri;
    best = 2'd0;
    best_pri = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (req[i] && pri[4*i +: 2] <= best_pri) begin
        best = 2'(i);
        best_pri = pri[4*i +: 2];
      end
    end
    arbitrate = best;
  endfunction

  assign grant = arbitrate(ready_v, pri_q); // RULE_18

  always_comb begin
    for (int n = 0; n < 4; n++) begin
      pop_v[n] = rd_v && in_seq && (sel_seq == 2'(n)) && (sub == `ASC_SUB_QUEUE) &&
                 (cnt_q[n] != 4'd0); // RULE_08
      unique case (trig_sel_q[4*n +: 4]) // RULE_20
        `ASC_TRIG_PROC: hit_v[n] = wr_at(`ASC_OFS_INITIATE) && avs_writedata[n]; // RULE_04
        `ASC_TRIG_ACMP: hit_v[n] = trig_acmp;
        `ASC_TRIG_PIN: hit_v[n] = trig_pin && !pin_q;
        `ASC_TRIG_TIMER: hit_v[n] = trig_timer;
        `ASC_TRIG_CONT: hit_v[n] = !((state_q != asc_pkg::ASC_IDLE) && (cur_q == 2'(n))); // RULE_24
        default: hit_v[n] = 1'b0;
      endcase
    end
  end

  // ===
  // configuration written by software
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enable_q <= 4'h0;
      mask_q <= 4'h0;
      mask_cmp_q <= 1'b0;
      trig_sel_q <= 16'h0000; // RULE_20
      pri_q <= `ASC_PRI_RESET;
      phase_q <= 4'h0;
      avg_q <= 3'h0; // RULE_22
      for (int n = 0; n < 4; n++) begin
        insel_q[n] <= 32'h0000_0000;
        stepctl_q[n] <= 32'h0000_0000;
      end
    end else begin
      if (wr_at(`ASC_OFS_ACTIVE)) begin
        enable_q <= avs_writedata[3:0];
      end
      if (wr_at(`ASC_OFS_IRQ_MASK)) begin
        mask_q <= avs_writedata[3:0];
        mask_cmp_q <= avs_writedata[`ASC_CMP_IRQ_POS];
      end
      if (wr_at(`ASC_OFS_TRIG_SEL)) begin
        trig_sel_q <= avs_writedata[15:0];
      end
      if (wr_at(`ASC_OFS_PRIORITY)) begin
        pri_q <= avs_writedata[15:0] & 16'h3333;
      end
      if (wr_at(`ASC_OFS_PHASE)) begin
        phase_q <= avs_writedata[3:0]; // RULE_21
      end
      if (wr_at(`ASC_OFS_AVG_CTL)) begin
        // codes above the maximum saturate at 64 conversions
        avg_q <= (avs_writedata[2:0] > `ASC_AVG_MAX) ? `ASC_AVG_MAX : avs_writedata[2:0];
      end
      if (wr_v && in_seq && sub == `ASC_SUB_INSEL) begin
        insel_q[sel_seq] <= avs_writedata;
      end
      if (wr_v && in_seq && sub == `ASC_SUB_STEPCTL) begin
        stepctl_q[sel_seq] <= avs_writedata;
      end
    end
  end

  // ===
  // trigger capture
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_q <= 1'b0;
      pend_q <= 4'h0;
    end else begin
      pin_q <= trig_pin;
      for (int n = 0; n < 4; n++) begin
        if (enable_q[n] && hit_v[n]) begin
          pend_q[n] <= 1'b1;
        end else if (state_q == asc_pkg::ASC_IDLE && ready_v != 4'h0 && grant == 2'(n)) begin
          pend_q[n] <= 1'b0;
        end else if (!enable_q[n]) begin
          pend_q[n] <= 1'b0;
        end
      end
    end
  end

  // ===
  // sequencing engine, one conversion at a time
  always_ff @(posedge sys_clk) begin // RULE_12
    if (reset) begin
      state_q <= asc_pkg::ASC_IDLE;
      cur_q <= 2'd0;
      step_q <= 3'd0;
      avg_cnt_q <= 7'd0;
      acc_q <= 16'h0000;
      conv_start <= 1'b0;
      conv_req <= '0;
    end else begin
      conv_start <= 1'b0;
      unique case (state_q)
        asc_pkg::ASC_IDLE: begin
          if (ready_v != 4'h0) begin
            cur_q <= grant;
            step_q <= 3'd0;
            avg_cnt_q <= 7'd0;
            acc_q <= 16'h0000;
            state_q <= asc_pkg::ASC_START;
          end
        end
        asc_pkg::ASC_START: begin
          conv_start <= 1'b1;
          conv_req.channel <= cur_chan;
          conv_req.phase <= phase_q; // RULE_21
          state_q <= asc_pkg::ASC_WAIT;
        end
        asc_pkg::ASC_WAIT: begin
          if (conv_done) begin
            acc_q <= acc_q + {6'h00, conv_data};
            // throughput drops by the averaging count
            if (avg_cnt_q == avg_total - 7'd1) begin // RULE_22
              state_q <= asc_pkg::ASC_STORE;
            end else begin
              avg_cnt_q <= avg_cnt_q + 7'd1;
              state_q <= asc_pkg::ASC_START;
            end
          end
        end
        asc_pkg::ASC_STORE: begin
          avg_cnt_q <= 7'd0;
          acc_q <= 16'h0000;
          if (last_step) begin // RULE_07
            state_q <= asc_pkg::ASC_IDLE;
          end else begin
            step_q <= step_q + 3'd1;
            state_q <= asc_pkg::ASC_START;
          end
        end
      endcase
    end
  end

  // ===
  // result queues
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ovf_q <= 4'h0;
      unf_q <= 4'h0;
      for (int n = 0; n < 4; n++) begin
        head_q[n] <= 3'd0;
        tail_q[n] <= 3'd0;
        cnt_q[n] <= 4'd0;
      end
    end else begin
      for (int n = 0; n < 4; n++) begin
        logic do_push;
        logic full;
        full = (cnt_q[n] == seq_depth(2'(n)));
        do_push = push_v && (cur_q == 2'(n)) && !full;
        if (do_push) begin
          mem_q[n][head_q[n]] <= avg_val; // RULE_02
          head_q[n] <= wrap_inc(head_q[n], 2'(n)); // RULE_08
        end
        if (pop_v[n]) begin
          tail_q[n] <= wrap_inc(tail_q[n], 2'(n));
        end
        cnt_q[n] <= 4'(cnt_q[n] + {3'd0, do_push} - {3'd0, pop_v[n]});
        // a new event beats a same-cycle clear
        if (push_v && cur_q == 2'(n) && full) begin
          ovf_q[n] <= 1'b1; // RULE_10 RULE_11
        end else if (wr_at(`ASC_OFS_OVERFLOW) && avs_writedata[n]) begin
          ovf_q[n] <= 1'b0;
        end
        if (rd_v && in_seq && sel_seq == 2'(n) && sub == `ASC_SUB_QUEUE &&
            cnt_q[n] == 4'd0) begin
          unf_q[n] <= 1'b1; // RULE_25 RULE_11
        end else if (wr_at(`ASC_OFS_UNDERFLOW) && avs_writedata[n]) begin
          unf_q[n] <= 1'b0;
        end
      end
    end
  end

  // ===
  // interrupt status and dma requests
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      raw_q <= 4'h0;
      cmp_raw_q <= 8'h00;
      irq <= 1'b0;
      dma_req <= 4'h0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        // irq only after the averaged value has been stored
        if (push_v && cur_q == 2'(n) && cur_ctl[`ASC_CTL_IE_BIT]) begin
          raw_q[n] <= 1'b1; // RULE_06 RULE_23
        end else if (wr_at(`ASC_OFS_MSK_CLR) && avs_writedata[n]) begin
          raw_q[n] <= 1'b0; // RULE_14
        end
        dma_req[n] <= push_v && (cur_q == 2'(n)) && cur_ctl[`ASC_CTL_IE_BIT]; // RULE_16
      end
      for (int k = 0; k < 8; k++) begin
        if (cmp_event[k]) begin
          cmp_raw_q[k] <= 1'b1;
        end else if (wr_at(`ASC_OFS_CMP_CLR) && avs_writedata[k]) begin
          cmp_raw_q[k] <= 1'b0; // RULE_15
        end
      end
      irq <= ((raw_q & mask_q) != 4'h0) || ((cmp_raw_q != 8'h00) && mask_cmp_q); // RULE_13
    end
  end

  // ===
  // read mux and handshake
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_seq) begin
      unique case (sub)
        `ASC_SUB_INSEL: rd_mux = insel_q[sel_seq];
        `ASC_SUB_STEPCTL: rd_mux = stepctl_q[sel_seq];
        `ASC_SUB_QUEUE: rd_mux = (cnt_q[sel_seq] != 4'd0) ?
                                   {22'h000000, mem_q[sel_seq][tail_q[sel_seq]]} : 32'h0;
        `ASC_SUB_QSTATE: begin // RULE_09
          rd_mux[2:0] = tail_q[sel_seq];
          rd_mux[`ASC_QS_HEAD_POS +: 3] = head_q[sel_seq];
          rd_mux[`ASC_QS_EMPTY_POS] = (cnt_q[sel_seq] == 4'd0);
          rd_mux[`ASC_QS_FULL_POS] = (cnt_q[sel_seq] == seq_depth(sel_seq));
        end
        default: rd_mux = 32'h0000_0000;
      endcase
    end else begin
      unique case (avs_address)
        `ASC_OFS_ACTIVE: rd_mux = {12'h000, pend_q, 12'h000, enable_q} |
          ((state_q != asc_pkg::ASC_IDLE) ? (32'h1 << (`ASC_BUSY_POS + cur_q)) : 32'h0);
        `ASC_OFS_IRQ_MASK: rd_mux = {15'h0000, mask_cmp_q, 12'h000, mask_q};
        `ASC_OFS_RAW_IRQ: rd_mux = {15'h0000, (cmp_raw_q != 8'h00), 12'h000, raw_q};
        `ASC_OFS_MSK_CLR: rd_mux = {15'h0000, (cmp_raw_q != 8'h00) && mask_cmp_q,
                                    12'h000, raw_q & mask_q}; // RULE_13
        `ASC_OFS_OVERFLOW: rd_mux = {28'h0000000, ovf_q};
        `ASC_OFS_UNDERFLOW: rd_mux = {28'h0000000, unf_q};
        `ASC_OFS_TRIG_SEL: rd_mux = {16'h0000, trig_sel_q};
        `ASC_OFS_PRIORITY: rd_mux = {16'h0000, pri_q};
        `ASC_OFS_PHASE: rd_mux = {28'h0000000, phase_q};
        `ASC_OFS_AVG_CTL: rd_mux = {29'h00000000, avg_q};
        `ASC_OFS_CMP_CLR: rd_mux = {24'h000000, cmp_raw_q};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      if (acc_v) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule

//--- sim/asc_conv_model.sv
// converter stand-in: one conv_done pulse for each conv_start
// assumes conv_req is held from conv_start until the next start
`timescale 1ns/1ns
module asc_conv_model (
  input wire logic sys_clk, // clock
  input wire logic reset, // synchronous, active high
  input wire logic slow, // long conversions when high
  input wire logic conv_start, // start pulse
  input wire asc_pkg::asc_conv_req_t conv_req, // channel of that start
  output logic conv_done, // done pulse
  output logic [9:0] conv_data // value with conv_done
);
  // ===
  // conversion timing
  logic [3:0] cnt_q;
  logic [9:0] val_q;
  always_ff @(posedge sys_clk) begin
    conv_done <= 1'b0;
    if (reset) begin
      cnt_q <= 4'h0;
      val_q <= 10'h000;
    end else if (conv_start) begin
      cnt_q <= slow ? 4'h9 : 4'h2;
      val_q <= {3'h5, conv_req.channel, 4'h9};
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      conv_done <= (cnt_q == 4'h1);
    end
  end
  // outside the done pulse the value is not held, so stale reads show up
  assign conv_data = conv_done ? val_q : ~val_q;
endmodule

//--- sim/asc_top_asserts.sv
// port-level checks of the sample sequencer control block
// assumes the top module's ports only; bound below
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_top_asserts (
  input wire logic sys_clk, // clock
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // wait
  input wire logic conv_start, // start pulse
  input wire asc_pkg::asc_conv_req_t conv_req, // request
  input wire logic conv_done, // done pulse
  input wire logic [3:0] dma_req, // burst requests
  input wire logic irq // masked interrupt
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ===
  // shadow of the phase setting
  logic [3:0] phase_q;
  logic taken_wr;
  assign taken_wr = avs_write && avs_waitrequest;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_q <= 4'h0;
    end else if (taken_wr && avs_address == `ASC_OFS_PHASE) begin
      phase_q <= avs_writedata[3:0];
    end
  end
  // ===
  // properties
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("access not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  property p_unmapped;
    avs_read && avs_waitrequest && avs_address == 8'hFC |=> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_conv_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("start too long");
  property p_req_hold;
    !conv_start |-> $stable(conv_req);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  property p_phase;
    conv_start |-> conv_req.phase == phase_q;
  endproperty
  a_phase: assert property (p_phase) else $error("wrong sample phase");
  property p_dma_cause;
    |dma_req |-> $past(conv_done, 2) || $past(conv_done, 3) || $past(conv_done, 4);
  endproperty
  a_dma_cause: assert property (p_dma_cause) else $error("burst without step");
  property p_reset_quiet;
    disable iff (1'b0) reset |=> avs_waitrequest && !conv_start && dma_req == 4'h0 && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet");
  property p_mask_off;
    taken_wr && avs_address == `ASC_OFS_IRQ_MASK && avs_writedata[16:0] == 17'h0 |=> ##1 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with mask off");
  c_start: cover property (conv_start);
  c_dma: cover property (|dma_req);
  c_irq: cover property ($rose(irq));
endmodule
bind asc_top asc_top_asserts u_asc_top_asserts (.sys_clk(sys_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .conv_start(conv_start), .conv_req(conv_req),
  .conv_done(conv_done), .dma_req(dma_req), .irq(irq));

//--- sim/tb.sv
// self-checking bench of the sample sequencer control block
// assumes asc_conv_model as converter and an Avalon-MM master here
`timescale 1ns/1ns
`include "asc_map.svh"
module tb;
  logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, irq, slow;
  logic trig_acmp, trig_pin, trig_timer, conv_start, conv_done;
  logic [7:0] avs_address, cmp_event;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [9:0] conv_data;
  logic [3:0] dma_req;
  asc_pkg::asc_conv_req_t conv_req;
  int mismatches, compares, starts, cycles;
  int dmas[4];
  logic [2:0] chq[$];
  asc_top u_asc_top (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trig_acmp(trig_acmp), .trig_pin(trig_pin), .trig_timer(trig_timer),
    .cmp_event(cmp_event), .conv_start(conv_start), .conv_req(conv_req),
    .conv_done(conv_done), .conv_data(conv_data), .dma_req(dma_req), .irq(irq));
  asc_conv_model u_asc_conv_model (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .conv_start(conv_start), .conv_req(conv_req), .conv_done(conv_done),
    .conv_data(conv_data));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ===
  // monitor and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (conv_start === 1'b1) begin
      starts++;
      chq.push_back(conv_req.channel);
    end
    for (int i = 0; i < 4; i++) if (dma_req[i] === 1'b1) dmas[i]++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // ===
  // helpers
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  function automatic logic [7:0] sa(input int n, input logic [2:0] s);
    return 8'h40 + 8'(n * 32) + {3'h0, s, 2'h0};
  endfunction
  function automatic logic [31:0] smp(input logic [2:0] c);
    return {22'h0, 3'h5, c, 4'h9};
  endfunction
  // bounded wait for conversions, then time for store and dma
  task automatic run_to(input int target);
    int t;
    t = 0;
    while (starts < target && t < 500) begin
      @(posedge sys_clk);
      t++;
    end
    repeat (30) @(posedge sys_clk);
  endtask
  // ===
  // scenarios
  task automatic t_reset();
    rchk(`ASC_OFS_PRIORITY, 32'h3210);
    rchk(`ASC_OFS_TRIG_SEL, 32'h0);
    rchk(`ASC_OFS_AVG_CTL, 32'h0);
    rchk(sa(0, `ASC_SUB_QSTATE), 32'h100);
    rchk(8'hFC, 32'h0);
  endtask
  task automatic t_setup();
    wr(sa(0, `ASC_SUB_INSEL), 32'h0001_3533);
    wr(sa(0, `ASC_SUB_STEPCTL), 32'h0002_4040);
    wr(sa(1, `ASC_SUB_INSEL), 32'h6666);
    wr(sa(1, `ASC_SUB_STEPCTL), 32'h2);
    wr(sa(2, `ASC_SUB_INSEL), 32'h7);
    wr(sa(2, `ASC_SUB_STEPCTL), 32'h2);
    wr(sa(3, `ASC_SUB_INSEL), 32'h2);
    wr(sa(3, `ASC_SUB_STEPCTL), 32'h6);
    wr(`ASC_OFS_IRQ_MASK, 32'h1);
    wr(`ASC_OFS_ACTIVE, 32'hF);
  endtask
  task automatic t_seq0();
    int b, d, i;
    slow <= 1'b1;
    b = starts;
    d = dmas[0];
    wr(`ASC_OFS_INITIATE, 32'h1);
    run_to(b + 5);
    check(starts, b + 5);
    check(dmas[0], d + 2);
    rchk(`ASC_OFS_RAW_IRQ, 32'h1);
    check(irq, 1'b1);
    rchk(sa(0, `ASC_SUB_QSTATE), 32'h50);
    for (i = 0; i < 5; i++) rchk(sa(0, `ASC_SUB_QUEUE), smp(3'(32'h13533 >> (4 * i))));
    rchk(sa(0, `ASC_SUB_QUEUE), 32'h0);
    rchk(`ASC_OFS_UNDERFLOW, 32'h1);
    rchk(sa(0, `ASC_SUB_QSTATE), 32'h155);
    slow <= 1'b0;
  endtask
  task automatic t_clear();
    wr(`ASC_OFS_MSK_CLR, 32'h0);
    check(irq, 1'b1);
    rchk(`ASC_OFS_MSK_CLR, 32'h1);
    wr(`ASC_OFS_MSK_CLR, 32'h1);
    check(irq, 1'b0);
    rchk(`ASC_OFS_RAW_IRQ, 32'h0);
    wr(`ASC_OFS_UNDERFLOW, 32'h1);
    rchk(`ASC_OFS_UNDERFLOW, 32'h0);
    cmp_event <= 8'h04;
    @(posedge sys_clk);
    cmp_event <= 8'h00;
    rchk(`ASC_OFS_CMP_CLR, 32'h4);
    rchk(`ASC_OFS_RAW_IRQ, 32'h0001_0000);
    wr(`ASC_OFS_CMP_CLR, 32'h4);
    rchk(`ASC_OFS_CMP_CLR, 32'h0);
  endtask
  task automatic t_overflow();
    int b;
    b = starts;
    wr(`ASC_OFS_INITIATE, 32'h8);
    run_to(b + 1);
    wr(`ASC_OFS_INITIATE, 32'h8);
    run_to(b + 2);
    rchk(`ASC_OFS_OVERFLOW, 32'h8);
    rchk(`ASC_OFS_RAW_IRQ, 32'h8);
    check(irq, 1'b0);
    rchk(sa(3, `ASC_SUB_QUEUE), smp(3'h2));
    wr(`ASC_OFS_OVERFLOW, 32'h8);
    rchk(`ASC_OFS_OVERFLOW, 32'h0);
  endtask
  task automatic t_priority();
    int b, i;
    for (i = 0; i < 2; i++) begin
      wr(`ASC_OFS_PRIORITY, (i == 1) ? 32'h3102 : 32'h3012);
      chq.delete();
      b = starts;
      wr(`ASC_OFS_INITIATE, 32'h6);
      run_to(b + 2);
      check(chq[0], (i == 1) ? 3'h6 : 3'h7);
    end
  endtask
  task automatic t_average();
    int b, d;
    b = starts;
    d = dmas[3];
    wr(`ASC_OFS_PHASE, 32'h5);
    wr(`ASC_OFS_AVG_CTL, 32'h2);
    wr(`ASC_OFS_INITIATE, 32'h8);
    run_to(b + 4);
    check(starts, b + 4);
    check(dmas[3], d + 1);
    rchk(sa(3, `ASC_SUB_QUEUE), smp(3'h2));
    wr(`ASC_OFS_AVG_CTL, 32'h0);
  endtask
  task automatic t_triggers();
    logic [3:0] code[3] = '{4'h1, 4'h4, 4'h5};
    int b, i;
    for (i = 0; i < 3; i++) begin
      b = starts;
      wr(`ASC_OFS_TRIG_SEL, {16'h0, code[i], 12'h0});
      trig_acmp <= (i == 0);
      trig_pin <= (i == 1);
      trig_timer <= (i == 2);
      @(posedge sys_clk);
      trig_acmp <= 1'b0;
      trig_timer <= 1'b0;
      run_to(b + 1);
      trig_pin <= 1'b0;
      check(starts, b + 1);
      rchk(sa(3, `ASC_SUB_QUEUE), smp(3'h2));
    end
    b = starts;
    wr(`ASC_OFS_TRIG_SEL, 32'hF000);
    repeat (40) @(posedge sys_clk);
    wr(`ASC_OFS_TRIG_SEL, 32'h0);
    check(starts >= b + 3, 1'b1);
  endtask
  // ===
  // main sequence
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    trig_acmp = 1'b0;
    trig_pin = 1'b0;
    trig_timer = 1'b0;
    cmp_event = 8'h00;
    slow = 1'b0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_setup();
    t_seq0();
    t_clear();
    t_overflow();
    t_priority();
    t_average();
    t_triggers();
    wr(`ASC_OFS_IRQ_MASK, 32'h8);
    check(irq, 1'b1);
    wr(`ASC_OFS_IRQ_MASK, 32'h0);
    check(irq, 1'b0);
    end_sim();
  end
endmodule
